//--- clw_pkg.sv
// Package for the charge level warning flag block
package clw_pkg;

  // ==========================================================
  // Widths
  localparam int CLW_CAP_W    = 16;  // Remaining capacity, mAh
  localparam int CLW_LVL_W    = 8;   // Threshold levels, mAh
  localparam int CLW_CHG_W    = 16;  // Signed charge sample per update
  localparam int CLW_ACC_W    = 32;  // Fractional charge accumulator

  // ==========================================================
  // Reset values and encodings
  localparam logic [CLW_CAP_W-1:0] CLW_CAP_RST   = 16'h03e8;
  localparam logic [CLW_ACC_W-1:0] CLW_ACC_RST   = 32'h0000_0000;
  localparam logic [CLW_LVL_W-1:0] CLW_LVL_OFF   = 8'hff; // Minus one
  localparam int                   CLW_FRAC_BITS = 12;   // Fraction bits, 4096 units per mAh

  // Flag status word carried to the host side
  typedef struct packed {
    logic final_capacity_warning_flag;
    logic first_capacity_warning_flag;
  } clw_flags_s;

  // Threshold configuration
  typedef struct packed {
    logic [CLW_LVL_W-1:0] first_warning_set_level;
    logic [CLW_LVL_W-1:0] final_warning_set_level;
    logic [CLW_LVL_W-1:0] final_warning_clear_level;
  } clw_cfg_s;

endpackage : clw_pkg

//--- clw_warning_flags.sv
// Charge counter and hysteretic capacity warning flags
`timescale 1ns/1ns
`default_nettype none

module clw_warning_flags
  import clw_pkg::*;
(
  // Clock and reset
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst_n,
  // Charge samples from the sense front end
  input  wire logic                  i_chg_valid,
  input  wire logic [CLW_CHG_W-1:0]  i_chg_sample,
  // Threshold configuration
  input  wire clw_cfg_s              i_cfg,
  // Host visible state
  output logic       [CLW_CAP_W-1:0] o_remaining_capacity_value,
  output var clw_flags_s             o_flags,
  output logic                       o_low_battery_pin
);

  // ==========================================================
  // Charge counter
  logic [CLW_ACC_W-1:0] acc_ff;
  logic [CLW_CAP_W-1:0] cap_ff;
  logic                 upd_ff;
  logic [CLW_ACC_W-1:0] nxt_acc;
  logic [CLW_CAP_W-1:0] nxt_cap;

  // Saturating capacity step from accumulated whole mAh
  function automatic logic [CLW_CAP_W-1:0] cap_step(
    input logic [CLW_CAP_W-1:0] cap,
    input logic [CLW_ACC_W-1:0] acc);
    logic signed [CLW_ACC_W-1:0] whole;
    logic signed [CLW_ACC_W:0]   sum;
    whole = $signed(acc) >>> CLW_FRAC_BITS;
    sum   = $signed({1'b0, {(CLW_ACC_W-CLW_CAP_W){1'b0}}, cap})
          + $signed({whole[CLW_ACC_W-1], whole});
    if (sum < 0) begin
      cap_step = '0;
    end else if (sum > $signed({{(CLW_ACC_W-CLW_CAP_W+1){1'b0}},
                                {CLW_CAP_W{1'b1}}})) begin
      cap_step = '1;
    end else begin
      cap_step = sum[CLW_CAP_W-1:0];
    end
  endfunction : cap_step

  always_comb begin
    nxt_acc = acc_ff + {{(CLW_ACC_W-CLW_CHG_W){i_chg_sample[CLW_CHG_W-1]}},
                        i_chg_sample};
    nxt_cap = cap_step(cap_ff, nxt_acc);
  end

  // Accumulator keeps only the fraction once whole mAh move to capacity
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      acc_ff <= CLW_ACC_RST;
      cap_ff <= CLW_CAP_RST;
      upd_ff <= 1'b0;
    end else begin
      upd_ff <= i_chg_valid;
      if (i_chg_valid) begin
        acc_ff <= {{(CLW_ACC_W-CLW_FRAC_BITS){1'b0}},
                   nxt_acc[CLW_FRAC_BITS-1:0]};
        cap_ff <= nxt_cap;
      end
    end
  end

  // ==========================================================
  // Warning flags
  logic first_ff;
  logic final_ff;
  logic [CLW_CAP_W-1:0] set1;
  logic [CLW_CAP_W-1:0] setf;
  logic [CLW_CAP_W-1:0] clrf;
  logic                 final_off;

  // Widen levels to capacity width
  always_comb begin
    set1      = {{(CLW_CAP_W-CLW_LVL_W){1'b0}}, i_cfg.first_warning_set_level};
    setf      = {{(CLW_CAP_W-CLW_LVL_W){1'b0}}, i_cfg.final_warning_set_level};
    clrf      = {{(CLW_CAP_W-CLW_LVL_W){1'b0}},
                 i_cfg.final_warning_clear_level};
    final_off = (i_cfg.final_warning_set_level == CLW_LVL_OFF);
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      first_ff <= 1'b0;
    end else if (upd_ff) begin
      if (cap_ff < set1) begin
        first_ff <= 1'b1;
      end else if (cap_ff > set1) begin
        first_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      final_ff <= 1'b0;
    end else if (upd_ff && !final_off && cap_ff < setf) begin
      final_ff <= 1'b1;
    end else if (upd_ff && final_ff && cap_ff > clrf) begin
      final_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_remaining_capacity_value <= CLW_CAP_RST;
      o_flags                    <= '0;
      o_low_battery_pin          <= 1'b0;
    end else begin
      o_remaining_capacity_value <= cap_ff;
      o_flags.first_capacity_warning_flag <= first_ff;
      o_flags.final_capacity_warning_flag <= final_ff;
      o_low_battery_pin <= first_ff;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  // Update with capacity under the first set level
  sequence s_upd_low1;
    upd_ff && cap_ff < set1;
  endsequence

  // Update with capacity exactly on the first set level
  sequence s_upd_on1;
    upd_ff && cap_ff == set1;
  endsequence

  // Update that sets the final warning unless it is disabled
  sequence s_upd_lowf;
    upd_ff && !final_off && cap_ff < setf;
  endsequence

  // Update that clears a set final warning with no competing set
  sequence s_upd_clrf;
    upd_ff && final_ff && cap_ff > clrf && (final_off || cap_ff >= setf);
  endsequence

  // Charge and discharge samples at the input
  sequence s_chg_in;
    i_chg_valid && !i_chg_sample[CLW_CHG_W-1];
  endsequence

  sequence s_dsg_in;
    i_chg_valid && i_chg_sample[CLW_CHG_W-1];
  endsequence

  // First warning hysteresis
  first_set_a: assert property (s_upd_low1 |=> first_ff)
    else $error("first warning not set below level");
  first_clr_a: assert property (upd_ff && cap_ff > set1 |=> !first_ff)
    else $error("first warning not cleared above level");
  first_even_a: assert property (s_upd_on1 |=> $stable(first_ff))
    else $error("first warning moved on its level");

  // Flag word and low battery pin
  pin_mirror_a: assert property (
    ##1 o_low_battery_pin == $past(first_ff))
    else $error("low battery pin does not mirror flag");
  flag_word_a: assert property (
    ##1 o_flags.final_capacity_warning_flag == $past(final_ff))
    else $error("flag word stale");
  flag_first_a: assert property (
    ##1 o_flags.first_capacity_warning_flag == $past(first_ff))
    else $error("first flag in word stale");

  // Final warning set, disable and clear
  final_set_a: assert property (s_upd_lowf |=> final_ff)
    else $error("final warning not set");
  final_off_a: assert property (!final_ff && final_off |=> !final_ff)
    else $error("final warning set while disabled");
  final_clr_a: assert property ($fell(final_ff) |->
    $past(upd_ff) && $past(cap_ff) > $past(clrf))
    else $error("final warning cleared without cause");
  final_drop_a: assert property (s_upd_clrf |=> !final_ff)
    else $error("final warning not cleared above level");

  // Flags hold between updates
  hold_flags_a: assert property (!upd_ff |=>
    $stable(first_ff) && $stable(final_ff))
    else $error("flag changed without update");

  // Capacity tracking
  cap_step_a: assert property (!i_chg_valid |=> $stable(cap_ff))
    else $error("capacity moved without a sample");
  cap_out_a: assert property (
    ##1 o_remaining_capacity_value == $past(cap_ff))
    else $error("capacity output stale");
  cap_up_a: assert property (s_chg_in |=> cap_ff >= $past(cap_ff))
    else $error("charge lowered capacity");
  cap_down_a: assert property (s_dsg_in |=> cap_ff <= $past(cap_ff))
    else $error("discharge raised capacity");

endmodule : clw_warning_flags

`default_nettype wire

//--- clw_host_model.sv
// Host side model that polls the flag word and low battery pin
`timescale 1ns/1ns
`default_nettype none
module clw_host_model
  import clw_pkg::*;
(
  // Clock
  input  wire logic       i_core_clk,
  // Gauge outputs
  input  wire clw_flags_s i_flags,
  input  wire logic       i_low_battery_pin,
  // Last word read
  output var clw_flags_s  o_read_flags
);
  // Poll each cycle, first flag taken from the pin
  always_ff @(posedge i_core_clk) begin
    o_read_flags <= {i_flags.final_capacity_warning_flag, i_low_battery_pin};
  end
endmodule : clw_host_model
`default_nettype wire

//--- tb_top.sv
// Self-checking bench for the charge level warning flags
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  miscompares++; $display("CHECK FAILED %0t value differs", $time); end end
module tb_top;
  import clw_pkg::*;
  logic                 i_core_clk = 1'b0;
  logic                 i_rst_n = 1'b0;
  logic                 i_chg_valid = 1'b0;
  logic [CLW_CHG_W-1:0] i_chg_sample = '0;
  clw_cfg_s             i_cfg = '0;
  logic [CLW_CAP_W-1:0] cap_w;
  clw_flags_s           flg_w;
  clw_flags_s           host_w;
  logic                 pin_w;
  int                   miscompares = 0;
  int                   samples_checked = 0;
  int                   cycles = 0;
  int                   tot;
  logic                 m1 = 1'b0;
  logic                 m2 = 1'b0;

  clw_warning_flags clw_warning_flags_i (.i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n), .i_chg_valid(i_chg_valid),
    .i_chg_sample(i_chg_sample), .i_cfg(i_cfg),
    .o_remaining_capacity_value(cap_w), .o_flags(flg_w),
    .o_low_battery_pin(pin_w));
  clw_host_model clw_host_model_i (.i_core_clk(i_core_clk),
    .i_flags(flg_w), .i_low_battery_pin(pin_w), .o_read_flags(host_w));

  // Clock and hang guard
  always #50 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 10000) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // One sample, then model update and compare
  task automatic step(input int s);
    int c;
    @(posedge i_core_clk);
    i_chg_valid <= 1'b1;
    i_chg_sample <= s[15:0];
    @(posedge i_core_clk);
    i_chg_valid <= 1'b0;
    tot += s;
    c = tot >>> 12;
    if (c < i_cfg.first_warning_set_level) m1 = 1'b1;
    else if (c > i_cfg.first_warning_set_level) m1 = 1'b0;
    if (i_cfg.final_warning_set_level != CLW_LVL_OFF &&
        c < i_cfg.final_warning_set_level) m2 = 1'b1;
    else if (m2 && c > i_cfg.final_warning_clear_level) m2 = 1'b0;
    repeat (3) @(posedge i_core_clk);
    #1;
    `CHK(cap_w, c[15:0])
    `CHK(flg_w, {m2, m1})
    @(posedge i_core_clk);
    #1;
    `CHK(host_w, {m2, m1})
  endtask : step

  initial begin
    void'($urandom(72121));
    repeat (5) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    tot = 1000 * 4096;
    @(posedge i_core_clk);
    #1;
    `CHK(cap_w, CLW_CAP_RST)
    `CHK(flg_w, 2'h0)
    `CHK(pin_w, 1'h0)
    for (int p = 0; p < 2; p++) begin
      @(posedge i_core_clk);
      i_cfg <= '{8'd150, (p == 1) ? CLW_LVL_OFF : 8'd75, 8'd100};
      while (tot > 40 * 4096)
        step(-($urandom_range(7, 1) * 4096 + $urandom_range(4095, 0)));
      while (tot < 220 * 4096)
        step($urandom_range(7, 1) * 4096 + $urandom_range(4095, 0));
      // level change alone leaves flags held
      @(posedge i_core_clk);
      i_cfg.first_warning_set_level <= 8'hff;
      repeat (4) @(posedge i_core_clk);
      #1;
      `CHK(flg_w, {m2, m1})
    end
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
